/* File: pkg/timer_channel_defs.vh */
// register map, field positions and reset values for the timer channel
`ifndef TIMER_CHANNEL_DEFS_VH
`define TIMER_CHANNEL_DEFS_VH

`define ADDR_CURRENT_COUNT   12'h000
`define ADDR_RELOAD_VALUE    12'h004
`define ADDR_BG_RELOAD       12'h008
`define ADDR_CHANNEL_CONTROL 12'h00C
`define ADDR_RAW_ZERO        12'h010
`define ADDR_MASKED_ZERO     12'h014
`define ADDR_COMBINED_MODE   12'h018
`define ADDR_IRQ_ENABLE      12'h01C
`define ADDR_IRQ_CLEAR       12'h020
`define ADDR_IRQ_STATUS      12'h024

`define CTRL_ENABLE_BIT      0
`define CTRL_ONE_SHOT_BIT    1
`define CTRL_IRQ_EN_BIT      2
`define FLAG_BIT             0
`define MODE64_BIT           0

`define WORD_ZERO            32'h0000_0000
`define WORD_ONE             32'h0000_0001
`define ADDR_WIDTH           12

`endif

/* File: hdl/timer_channel.v */
// one 32-bit down-counting timer channel with an APB register slave
`default_nettype none
`include "timer_channel_defs.vh"

module timer_channel (
	input  wire        CLK,
	input  wire        ARST_N,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [11:0] PADDR,
	input  wire [31:0] PWDATA,
	output wire [31:0] PRDATA,
	output wire        PREADY,
	output wire        PSLVERR,
	output wire        ZERO_INTERRUPT_OUT,
	output wire        ZERO_EVENT_IRQ
);

	reg  [31:0] count_q;
	reg  [31:0] count_d;
	reg  [31:0] reload_q;
	reg  [31:0] reload_d;
	reg         count_enable_q;
	reg         count_enable_d;
	reg         one_shot_q;
	reg         one_shot_d;
	reg         zero_irq_en_q;
	reg         zero_irq_en_d;
	reg         raw_flag_q;
	reg         raw_flag_d;
	reg         combined_q;
	reg         combined_d;
	reg         evt_en_q;
	reg         evt_en_d;
	reg         evt_q;
	reg         evt_d;
	reg         halted_q;
	reg         halted_d;
	reg  [31:0] rdata_q;
	reg  [31:0] rdata_d;
	reg         slverr_q;
	reg         slverr_d;
	reg         hit;
	wire        wr;
	wire        rd;
	wire        setup;
	wire        reach_zero;

	// single-cycle access: every transfer completes in its first access cycle
	assign PREADY  = 1'h1;
	assign setup   = PSEL & ~PENABLE;
	assign wr      = PSEL & PENABLE & PWRITE;
	assign rd      = setup & ~PWRITE;
	assign PRDATA  = rdata_q;
	assign PSLVERR = slverr_q & PSEL & PENABLE;

	// zero event when the running counter stands at one; a halted one-shot does not retrigger
	assign reach_zero = count_enable_q & ~halted_q & (count_q == `WORD_ONE);

	// both interrupt outputs are plain levels; software clears their cause
	assign ZERO_INTERRUPT_OUT = raw_flag_q & zero_irq_en_q;
	assign ZERO_EVENT_IRQ     = evt_q & evt_en_q;

	always @* begin
		// unmapped offsets answer with an error and read as zero
		hit = 1'h1;
		case (PADDR)
			`ADDR_CURRENT_COUNT:   hit = 1'h1;
			`ADDR_RELOAD_VALUE:    hit = 1'h1;
			`ADDR_BG_RELOAD:       hit = 1'h1;
			`ADDR_CHANNEL_CONTROL: hit = 1'h1;
			`ADDR_RAW_ZERO:        hit = 1'h1;
			`ADDR_MASKED_ZERO:     hit = 1'h1;
			`ADDR_COMBINED_MODE:   hit = 1'h1;
			`ADDR_IRQ_ENABLE:      hit = 1'h1;
			`ADDR_IRQ_CLEAR:       hit = 1'h1;
			`ADDR_IRQ_STATUS:      hit = 1'h1;
			default:               hit = 1'h0;
		endcase
	end

	always @* begin
		rdata_d  = rdata_q;
		slverr_d = 1'h0;
		if (setup) begin
			slverr_d = ~hit;
		end
		// read data is taken at the end of setup and stands through the access cycle
		if (rd) begin
			rdata_d = `WORD_ZERO;
			case (PADDR)
				`ADDR_CURRENT_COUNT: begin
					if (!combined_q) begin
						rdata_d = count_q;
					end
				end
				`ADDR_RELOAD_VALUE: begin
					if (!combined_q) begin
						rdata_d = reload_q;
					end
				end
				`ADDR_BG_RELOAD: begin
					if (!combined_q) begin
						rdata_d = reload_q;
					end
				end
				`ADDR_CHANNEL_CONTROL: begin
					if (!combined_q) begin
						rdata_d[`CTRL_ENABLE_BIT]   = count_enable_q;
						rdata_d[`CTRL_ONE_SHOT_BIT] = one_shot_q;
						rdata_d[`CTRL_IRQ_EN_BIT]   = zero_irq_en_q;
					end
				end
				`ADDR_RAW_ZERO:      rdata_d[`FLAG_BIT] = raw_flag_q;
				`ADDR_MASKED_ZERO:   rdata_d[`FLAG_BIT] = raw_flag_q & zero_irq_en_q;
				`ADDR_COMBINED_MODE: rdata_d[`MODE64_BIT] = combined_q;
				`ADDR_IRQ_ENABLE:    rdata_d[`FLAG_BIT] = evt_en_q;
				`ADDR_IRQ_STATUS:    rdata_d[`FLAG_BIT] = evt_q;
				`ADDR_IRQ_CLEAR:     rdata_d = `WORD_ZERO;
				default:             rdata_d = `WORD_ZERO;
			endcase
		end
	end

	always @* begin
		count_d        = count_q;
		reload_d       = reload_q;
		count_enable_d = count_enable_q;
		one_shot_d     = one_shot_q;
		zero_irq_en_d  = zero_irq_en_q;
		combined_d     = combined_q;
		evt_en_d       = evt_en_q;
		halted_d       = halted_q;

		// counting; the zero event is taken at a count of one, so a periodic
		// count never shows zero while it runs
		if (count_enable_q && !halted_q) begin
			if (count_q == `WORD_ZERO) begin
				count_d = reload_q;
			end else if (reach_zero) begin
				if (one_shot_q) begin
					count_d  = `WORD_ZERO;
					halted_d = 1'h1;
				end else begin
					count_d = reload_q;
				end
			end else begin
				count_d = count_q - `WORD_ONE;
			end
		end

		if (wr) begin
			case (PADDR)
				`ADDR_RELOAD_VALUE: begin
					if (!combined_q) begin
						reload_d = PWDATA;
						count_d  = PWDATA;
						// any nonzero write to the reload value lifts a one-shot halt; a background reload write does not
						if (PWDATA != `WORD_ZERO) begin
							halted_d = 1'h0;
						end
					end
				end
				`ADDR_BG_RELOAD: begin
					if (!combined_q) begin
						reload_d = PWDATA;
					end
				end
				`ADDR_CHANNEL_CONTROL: begin
					if (!combined_q) begin
						count_enable_d = PWDATA[`CTRL_ENABLE_BIT];
						one_shot_d     = PWDATA[`CTRL_ONE_SHOT_BIT];
						zero_irq_en_d  = PWDATA[`CTRL_IRQ_EN_BIT];
						// back to periodic also restarts a halted one-shot
						if (!PWDATA[`CTRL_ONE_SHOT_BIT]) begin
							halted_d = 1'h0;
						end
						// enabling from idle: a zero count is reloaded first
						if (PWDATA[`CTRL_ENABLE_BIT] && !count_enable_q) begin
							halted_d = 1'h0;
							if (count_q == `WORD_ZERO) begin
								count_d = reload_q;
							end else begin
								count_d = count_q;
							end
						end
					end
				end
				`ADDR_COMBINED_MODE: begin
					combined_d = PWDATA[`MODE64_BIT];
					// entering combined operation clears channel control
					if (PWDATA[`MODE64_BIT]) begin
						count_enable_d = 1'h0;
						one_shot_d     = 1'h0;
						zero_irq_en_d  = 1'h0;
					end
				end
				`ADDR_IRQ_ENABLE: evt_en_d = PWDATA[`FLAG_BIT];
				default: begin
				end
			endcase
		end
	end

	// sticky flags: a zero event in the clearing cycle wins over the clear
	always @* begin
		raw_flag_d = raw_flag_q;
		if (wr && (PADDR == `ADDR_RAW_ZERO) && PWDATA[`FLAG_BIT]) begin
			raw_flag_d = 1'h0;
		end
		// writes to the masked status address touch nothing
		if (reach_zero) begin
			raw_flag_d = 1'h1;
		end
	end

	// event status mirrors the raw flag but has its own clear and enable
	always @* begin
		evt_d = evt_q;
		if (wr && (PADDR == `ADDR_IRQ_CLEAR) && PWDATA[`FLAG_BIT]) begin
			evt_d = 1'h0;
		end
		if (reach_zero) begin
			evt_d = 1'h1;
		end
	end

	// one flop group per register; every reset value is zero
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			count_q <= `WORD_ZERO;
		end else begin
			count_q <= count_d;
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			reload_q <= `WORD_ZERO;
		end else begin
			reload_q <= reload_d;
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			count_enable_q <= 1'h0;
		end else begin
			count_enable_q <= count_enable_d;
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			one_shot_q <= 1'h0;
		end else begin
			one_shot_q <= one_shot_d;
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			zero_irq_en_q <= 1'h0;
		end else begin
			zero_irq_en_q <= zero_irq_en_d;
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			raw_flag_q <= 1'h0;
		end else begin
			raw_flag_q <= raw_flag_d;
		end
	end

	// combined operation freezes this channel's control and reload access
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			combined_q <= 1'h0;
		end else begin
			combined_q <= combined_d;
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			evt_en_q <= 1'h0;
		end else begin
			evt_en_q <= evt_en_d;
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			evt_q <= 1'h0;
		end else begin
			evt_q <= evt_d;
		end
	end

	// halt marks a one-shot that has run out
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			halted_q <= 1'h0;
		end else begin
			halted_q <= halted_d;
		end
	end

	// read data and error flag belong to the bus side
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rdata_q <= `WORD_ZERO;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			slverr_q <= 1'h0;
		end else begin
			slverr_q <= slverr_d;
		end
	end

endmodule

`default_nettype wire

/* File: dv/timer_channel_properties.sv */
// concurrent checks on the timer channel ports
`default_nettype none
`include "timer_channel_defs.vh"
module timer_channel_properties (
	input wire logic        CLK,
	input wire logic        ARST_N,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        ZERO_INTERRUPT_OUT,
	input wire logic        ZERO_EVENT_IRQ
);
	timeunit 1ns;
	timeprecision 1ns;
	wire wr = PSEL && PENABLE && PWRITE;
	wire rd = PSEL && PENABLE && !PWRITE;
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	a_raw_clear: assert property (
		wr && PADDR == `ADDR_RAW_ZERO && PWDATA[0] |=> !ZERO_INTERRUPT_OUT)
		else $error("flag clear ignored");
	a_event_clear: assert property (
		wr && PADDR == `ADDR_IRQ_CLEAR && PWDATA[0] |=> !ZERO_EVENT_IRQ)
		else $error("event clear ignored");
	a_irq_fall_cause: assert property (
		$fell(ZERO_INTERRUPT_OUT) |-> $past(PWRITE) && $past(PENABLE))
		else $error("irq fell without write");
	a_masked_ro: assert property (
		wr && PADDR == `ADDR_MASKED_ZERO && ZERO_INTERRUPT_OUT |=> ZERO_INTERRUPT_OUT)
		else $error("masked write changed irq");
	a_masked_read: assert property (
		rd && PADDR == `ADDR_MASKED_ZERO |-> PRDATA == {31'h0000_0000, $past(ZERO_INTERRUPT_OUT)})
		else $error("masked read differs");
	a_raw_read: assert property (
		rd && PADDR == `ADDR_RAW_ZERO |-> PRDATA[31:1] == 31'h0000_0000)
		else $error("raw upper bits set");
	a_ctrl_reserved: assert property (
		rd && PADDR == `ADDR_CHANNEL_CONTROL |-> PRDATA[31:3] == 29'h0000_0000)
		else $error("control reserved set");
	a_reset_quiet: assert property (
		$rose(ARST_N) |-> !ZERO_INTERRUPT_OUT && !ZERO_EVENT_IRQ && PRDATA == 32'h0000_0000)
		else $error("outputs not cleared");
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// register-level bench for the timer channel
`default_nettype none
`include "timer_channel_defs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] cnt = `ADDR_CURRENT_COUNT, rld = `ADDR_RELOAD_VALUE;
	localparam logic [11:0] bgr = `ADDR_BG_RELOAD, ctl = `ADDR_CHANNEL_CONTROL;
	localparam logic [11:0] raw = `ADDR_RAW_ZERO, msk = `ADDR_MASKED_ZERO;
	localparam logic [11:0] cmb = `ADDR_COMBINED_MODE, ien = `ADDR_IRQ_ENABLE;
	localparam logic [11:0] icl = `ADDR_IRQ_CLEAR, ist = `ADDR_IRQ_STATUS;
	localparam logic [31:0] one = `WORD_ONE, zro = `WORD_ZERO;
	logic        CLK = 1'h0, ARST_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, err;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0000_0000, PRDATA, rdv;
	logic        PREADY, PSLVERR, ZERO_INTERRUPT_OUT, ZERO_EVENT_IRQ;
	int          miscompares = 0, compares = 0;
	timer_channel timer_channel_inst (
		.CLK               (CLK),
		.ARST_N            (ARST_N),
		.PSEL              (PSEL),
		.PENABLE           (PENABLE),
		.PWRITE            (PWRITE),
		.PADDR             (PADDR),
		.PWDATA            (PWDATA),
		.PRDATA            (PRDATA),
		.PREADY            (PREADY),
		.PSLVERR           (PSLVERR),
		.ZERO_INTERRUPT_OUT(ZERO_INTERRUPT_OUT),
		.ZERO_EVENT_IRQ    (ZERO_EVENT_IRQ)
	);
	always #25 CLK = ~CLK;
	task wrap_up;
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] g, e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one apb transfer; request held until pready is seen high
	task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge CLK);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'h1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'h1 && n < 9);
		if (PREADY !== 1'h1) begin
			miscompares++;
			wrap_up();
		end
		rdv = PRDATA;
		err = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		xf(1'h0, a, zro);
		chk(rdv, e);
	endtask
	initial begin
		repeat (16) @(posedge CLK);
		ARST_N <= 1'h1;
		rd(raw, zro);
		xf(1'h1, rld, 32'h0000_0014);
		rd(cnt, 32'h0000_0014);
		xf(1'h1, ctl, 32'h0000_0005);
		xf(1'h1, bgr, 32'h0000_0064);
		xf(1'h0, cnt, zro);
		chk(rdv < 32'h0000_0014, one);
		repeat (30) @(posedge CLK);
		xf(1'h0, cnt, zro);
		chk(rdv > 32'h0000_0032, one);
		rd(raw, one);
		chk(ZERO_INTERRUPT_OUT, one);
		xf(1'h1, msk, one);
		rd(msk, one);
		xf(1'h1, raw, zro);
		rd(raw, one);
		xf(1'h1, raw, one);
		rd(raw, zro);
		xf(1'h1, ctl, 32'h0000_0003);
		xf(1'h1, rld, 32'h0000_0005);
		repeat (20) @(posedge CLK);
		rd(cnt, zro);
		rd(raw, one);
		rd(msk, zro);
		xf(1'h1, ien, one);
		rd(ctl, 32'h0000_0003);
		chk(ZERO_EVENT_IRQ, one);
		rd(ist, one);
		xf(1'h1, icl, one);
		rd(msk, zro);
		chk(ZERO_EVENT_IRQ, zro);
		rd(ist, zro);
		xf(1'h1, cmb, one);
		xf(1'h1, bgr, 32'h0000_0007);
		xf(1'h1, ctl, 32'h0000_0005);
		rd(ctl, zro);
		rd(bgr, zro);
		xf(1'h1, cmb, zro);
		rd(bgr, 32'h0000_0005);
		xf(1'h1, ctl, one);
		xf(1'h0, cnt, zro);
		chk(rdv != zro && rdv <= 32'h0000_0005, one);
		xf(1'h1, 12'h040, one);
		chk(err, one);
		rd(12'h040, zro);
		@(posedge CLK);
		ARST_N <= 1'h0;
		repeat (2) @(posedge CLK);
		ARST_N <= 1'h1;
		rd(raw, zro);
		rd(ctl, zro);
		rd(bgr, zro);
		wrap_up();
	end
endmodule
bind timer_channel timer_channel_properties timer_channel_properties_inst (
	.CLK               (CLK),
	.ARST_N            (ARST_N),
	.PSEL              (PSEL),
	.PENABLE           (PENABLE),
	.PWRITE            (PWRITE),
	.PADDR             (PADDR),
	.PWDATA            (PWDATA),
	.PRDATA            (PRDATA),
	.ZERO_INTERRUPT_OUT(ZERO_INTERRUPT_OUT),
	.ZERO_EVENT_IRQ    (ZERO_EVENT_IRQ)
);
`default_nettype wire
